// >>> include/hdvpg_defs.vh
// Constants for the HD video pattern generator: bus map, ROM word layouts,
// timing-reference words and ramp figures.
// Assumes inclusion by bare name from the generator's source file.
`ifndef HDVPG_DEFS_VH
`define HDVPG_DEFS_VH

// Register map, byte addresses on a 32-bit Avalon-MM slave.
`define HDVPG_AW 4
`define HDVPG_ADDR_CTRL 4'h0
`define HDVPG_ADDR_STATUS 4'h4
// Control register fields.
`define HDVPG_CTRL_STD 2:0
`define HDVPG_CTRL_BARS 3
`define HDVPG_CTRL_OPT_REG 12:8
`define HDVPG_CTRL_OPT_EN 13
`define HDVPG_CTRL_RST 14'h0000
// Status register fields.
`define HDVPG_ST_LINE 10:0
`define HDVPG_ST_FIELD 16
`define HDVPG_ST_VBLANK 17
`define HDVPG_ST_HBLANK 18

// Horizontal ROM word.
`define HDVPG_HW_NEXT 5:0
`define HDVPG_HW_EVT 16:6
`define HDVPG_HW_REGION 21:17
`define HDVPG_HW_CLR 22
`define HDVPG_HW_VINC 23
`define HDVPG_HW_TRS 24
`define HDVPG_HW_EAV 25
`define HDVPG_HW_BLANK 26
`define HDVPG_HW_WIDE 27
// Vertical ROM word.
`define HDVPG_VW_NEXT 5:0
`define HDVPG_VW_EVT 16:6
`define HDVPG_VW_BAND_FULL 20:17
`define HDVPG_VW_BAND_BARS 24:21
`define HDVPG_VW_BLANK 25
`define HDVPG_VW_FIELD 26
`define HDVPG_VW_CLR 27
// Colour ROM word.
`define HDVPG_CW_Y 9:0
`define HDVPG_CW_C 19:10
`define HDVPG_CW_RELOAD 20
`define HDVPG_CW_RAMP 21

// ROM sizes.
`define HDVPG_HORIZONTAL_STATE_ROM_DEPTH 512
`define HDVPG_VERTICAL_STATE_ROM_DEPTH 512
`define HDVPG_COLOUR_VALUE_ROM_DEPTH 1024

// Reset states and counts.
`define HDVPG_STATE_INIT 6'h00
`define HDVPG_HCNT_INIT 12'h000
`define HDVPG_LINE_FIRST 11'h001

// Timing reference words.
`define HDVPG_TRS_W0 10'h3ff
`define HDVPG_TRS_W1 10'h000
`define HDVPG_TRS_XYZ_IDX 2'h3
`define HDVPG_TRS_W0_IDX 2'h0

// Region and band codes with special meaning, and the black and zero-chroma levels.
`define HDVPG_REGION_OPT 5'h0a
`define HDVPG_BAND_BLANK 4'hf
`define HDVPG_Y_BLACK 10'h040
`define HDVPG_C_ZERO 10'h200

// Ramp accumulator: 10 integer bits, 8 fractional bits, one guard bit.
`define HDVPG_ACC_W 19
`define HDVPG_ACC_FRAC 8
`define HDVPG_RAMP_INIT 19'h04000
`define HDVPG_RAMP_INC_1920 19'h00074
`define HDVPG_RAMP_INC_1280 19'h000af
`define HDVPG_ROUND_ONE 10'h001

`endif

// >>> src/hdvpg_top.v
// HD video pattern generator: horizontal and vertical ROM state machines,
// colour ROM with luma ramp, timing flags and an Avalon-MM control slave.
// Assumes one video clock, switched in frequency outside, and a downstream
// transmitter that inserts line numbers and serialises the stream.
`timescale 1ns/1ps
`default_nettype none
`include "hdvpg_defs.vh"
module hdvpg_top
(
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Avalon-MM slave
  input wire [`HDVPG_AW-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Video stream
  output reg [9:0] luma,
  output reg [9:0] chroma,
  output reg trs,
  output reg xyz,
  output reg field,
  output reg v_blank,
  output reg h_blank,
  output reg [10:0] line_num
);
  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flip-flops.
  reg rst_meta_q;
  reg rst_n_q;
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Pattern tables. Contents are a default format; every standard code maps
  // to it until tables for other format groups are filled in.
  function [31:0] horizontal_state_rom_word;
    input [5:0] st;
    reg [31:0] w;
    integer evt;
    begin
      w = 32'h0000_0000;
      evt = 0;
      case (st)
        6'h00:
        begin
          evt = 1;
          w[`HDVPG_HW_NEXT] = 6'h01;
          w[`HDVPG_HW_TRS] = 1'b1;
          w[`HDVPG_HW_EAV] = 1'b1;
          w[`HDVPG_HW_BLANK] = 1'b1;
        end
        6'h01:
        begin
          evt = 137;
          w[`HDVPG_HW_NEXT] = 6'h02;
          w[`HDVPG_HW_REGION] = 5'h01;
          w[`HDVPG_HW_BLANK] = 1'b1;
        end
        6'h02:
        begin
          evt = 139;
          w[`HDVPG_HW_NEXT] = 6'h03;
          w[`HDVPG_HW_REGION] = 5'h02;
          w[`HDVPG_HW_TRS] = 1'b1;
          w[`HDVPG_HW_BLANK] = 1'b1;
        end
        default:
        begin
          if (st < 6'h0b)
          begin
            evt = 139 + 120 * (st - 2);
            w[`HDVPG_HW_REGION] = st[4:0];
            w[`HDVPG_HW_NEXT] = (st == 6'h0a) ? 6'h00 : st + 6'h01;
            w[`HDVPG_HW_CLR] = (st == 6'h0a);
            w[`HDVPG_HW_VINC] = (st == 6'h0a);
          end
        end
      endcase
      w[`HDVPG_HW_EVT] = evt[10:0];
      w[`HDVPG_HW_WIDE] = 1'b1;
      horizontal_state_rom_word = w;
    end
  endfunction
  function [31:0] vertical_state_rom_word;
    input [5:0] st;
    reg [31:0] w;
    integer evt;
    begin
      w = 32'h0000_0000;
      evt = 0;
      w[`HDVPG_VW_BAND_BARS] = 4'h5;
      case (st)
        6'h00:
        begin
          evt = 41;
          w[`HDVPG_VW_BAND_FULL] = `HDVPG_BAND_BLANK;
          w[`HDVPG_VW_BAND_BARS] = `HDVPG_BAND_BLANK;
          w[`HDVPG_VW_BLANK] = 1'b1;
        end
        6'h01: evt = 581;
        6'h02: evt = 661;
        6'h03: evt = 741;
        6'h04: evt = 1121;
        6'h05:
        begin
          evt = 1125;
          w[`HDVPG_VW_BAND_FULL] = `HDVPG_BAND_BLANK;
          w[`HDVPG_VW_BAND_BARS] = `HDVPG_BAND_BLANK;
          w[`HDVPG_VW_BLANK] = 1'b1;
          w[`HDVPG_VW_CLR] = 1'b1;
        end
        default: evt = 0;
      endcase
      if (st >= 6'h01 && st <= 6'h04)
        w[`HDVPG_VW_BAND_FULL] = st[3:0];
      w[`HDVPG_VW_NEXT] = (st >= 6'h05) ? 6'h00 : st + 6'h01;
      w[`HDVPG_VW_EVT] = evt[10:0];
      vertical_state_rom_word = w;
    end
  endfunction
  function [31:0] colour_value_rom_word;
    input [9:0] a;
    reg [31:0] w;
    reg [3:0] band;
    reg [4:0] reg_c;
    reg [9:0] y;
    reg [9:0] cb;
    reg [9:0] cr;
    begin
      w = 32'h0000_0000;
      band = a[9:6];
      reg_c = a[5:1];
      y = `HDVPG_Y_BLACK;
      cb = `HDVPG_C_ZERO;
      cr = `HDVPG_C_ZERO;
      if (band != `HDVPG_BAND_BLANK && reg_c >= 5'h03 && reg_c <= 5'h0a)
      begin
        if (band == 4'h4)
        begin
          w[`HDVPG_CW_RELOAD] = (reg_c == 5'h03);
          w[`HDVPG_CW_RAMP] = (reg_c >= 5'h04 && reg_c <= 5'h09);
          y = (reg_c == 5'h0a) ? 10'h3ac : `HDVPG_Y_BLACK;
        end
        else
        begin
          case (reg_c)
            5'h03: begin y = 10'h19c; end
            5'h04: begin y = 10'h2d0; end
            5'h05: begin y = 10'h2a8; cb = 10'h0b0; cr = 10'h220; end
            5'h06: begin y = 10'h248; cb = 10'h274; cr = 10'h0b0; end
            5'h07: begin y = 10'h220; cb = 10'h184; cr = 10'h0d4; end
            5'h08: begin y = 10'h0e8; cb = 10'h27c; cr = 10'h32c; end
            5'h09: begin y = 10'h0c0; cb = 10'h18c; cr = 10'h350; end
            default: begin y = 10'h060; cb = 10'h350; cr = 10'h1e4; end
          endcase
        end
      end
      w[`HDVPG_CW_Y] = y;
      w[`HDVPG_CW_C] = a[0] ? cr : cb;
      colour_value_rom_word = w;
    end
  endfunction

  // read-only tables
  // Filled once at configuration; no process ever writes these arrays.
  reg [31:0] horizontal_state_rom [0:`HDVPG_HORIZONTAL_STATE_ROM_DEPTH-1];
  reg [31:0] vertical_state_rom [0:`HDVPG_VERTICAL_STATE_ROM_DEPTH-1];
  reg [31:0] colour_value_rom [0:`HDVPG_COLOUR_VALUE_ROM_DEPTH-1];
  integer i;
  initial
  begin
    for (i = 0; i < `HDVPG_HORIZONTAL_STATE_ROM_DEPTH; i = i + 1)
      horizontal_state_rom[i] = horizontal_state_rom_word(i[5:0]);
    for (i = 0; i < `HDVPG_VERTICAL_STATE_ROM_DEPTH; i = i + 1)
      vertical_state_rom[i] = vertical_state_rom_word(i[5:0]);
    for (i = 0; i < `HDVPG_COLOUR_VALUE_ROM_DEPTH; i = i + 1)
      colour_value_rom[i] = colour_value_rom_word(i[9:0]);
  end
  ////////////////////////////////////////////////////////////////////////////
  // Control register and Avalon-MM slave.
  reg [13:0] ctrl_q;
  reg ack_q;
  wire req = avs_read | avs_write;
  wire [2:0] std_sel = ctrl_q[`HDVPG_CTRL_STD];
  wire bars_sel = ctrl_q[`HDVPG_CTRL_BARS];
  wire [4:0] opt_region = ctrl_q[`HDVPG_CTRL_OPT_REG];
  wire opt_en = ctrl_q[`HDVPG_CTRL_OPT_EN];
  // One wait cycle per access; the answer comes on the second edge.
  assign avs_waitrequest = req & ~ack_q;
  always @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ack_q <= 1'b0;
      ctrl_q <= `HDVPG_CTRL_RST;
      avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      if (avs_read & ~ack_q)
      begin
        case (avs_address)
          `HDVPG_ADDR_CTRL: avs_readdata <= {18'h00000, ctrl_q};
          `HDVPG_ADDR_STATUS: avs_readdata <= {13'h0000, h_blank, v_blank, field, 5'h00, line_num};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
      if (avs_write && ack_q && avs_address == `HDVPG_ADDR_CTRL)
      begin
        if (avs_byteenable[0])
          ctrl_q[7:0] <= avs_writedata[7:0];
        if (avs_byteenable[1])
          ctrl_q[13:8] <= avs_writedata[13:8];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Horizontal sequencer.
  reg [11:0] hcnt_q;
  reg [5:0] hstate_q;
  wire [31:0] hw = horizontal_state_rom[{std_sel, hstate_q}];
  wire hmatch = (hcnt_q[11:1] == hw[`HDVPG_HW_EVT]) & hcnt_q[0];
  wire line_adv = hmatch & hw[`HDVPG_HW_VINC];
  always @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      hcnt_q <= `HDVPG_HCNT_INIT;
      hstate_q <= `HDVPG_STATE_INIT;
    end
    else
    begin
      if (hmatch & hw[`HDVPG_HW_CLR])
        hcnt_q <= `HDVPG_HCNT_INIT;
      else
        hcnt_q <= hcnt_q + 12'h001;
      if (hmatch)
        hstate_q <= hw[`HDVPG_HW_NEXT];
    end
  end

  // region override
  // The bars table cannot carry user fields, so software may swap one code.
  wire [4:0] rom_region = hw[`HDVPG_HW_REGION];
  wire [4:0] h_region = (opt_en && rom_region == `HDVPG_REGION_OPT) ? opt_region : rom_region;
  ////////////////////////////////////////////////////////////////////////////
  // Vertical sequencer.
  reg [10:0] line_q;
  reg [5:0] vstate_q;
  wire [31:0] vw = vertical_state_rom[{std_sel, vstate_q}];
  wire vmatch = line_q == vw[`HDVPG_VW_EVT];
  always @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      line_q <= `HDVPG_LINE_FIRST;
      vstate_q <= `HDVPG_STATE_INIT;
    end
    else if (line_adv)
    begin
      if (vmatch & vw[`HDVPG_VW_CLR])
        line_q <= `HDVPG_LINE_FIRST;
      else
        line_q <= line_q + 11'h001;
      if (vmatch)
        vstate_q <= vw[`HDVPG_VW_NEXT];
    end
  end

  wire [3:0] v_band = bars_sel ? vw[`HDVPG_VW_BAND_BARS] : vw[`HDVPG_VW_BAND_FULL];
  ////////////////////////////////////////////////////////////////////////////
  // Output section.
  // colour ROM address
  wire [31:0] cw = colour_value_rom[{v_band, h_region, hcnt_q[0]}];
  reg [`HDVPG_ACC_W-1:0] acc_q;
  wire [`HDVPG_ACC_W-1:0] ramp_inc = hw[`HDVPG_HW_WIDE] ? `HDVPG_RAMP_INC_1920 : `HDVPG_RAMP_INC_1280;
  always @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      acc_q <= `HDVPG_RAMP_INIT;
    else if (cw[`HDVPG_CW_RELOAD])
      acc_q <= `HDVPG_RAMP_INIT;
    else if (cw[`HDVPG_CW_RAMP])
      acc_q <= acc_q + ramp_inc;
  end

  wire [9:0] ramp_y = acc_q[`HDVPG_ACC_FRAC+9:`HDVPG_ACC_FRAC] +
    (acc_q[`HDVPG_ACC_FRAC-1] ? `HDVPG_ROUND_ONE : 10'h000);
  // Timing reference word built from field, blanking and EAV/SAV flags.
  wire f_b = vw[`HDVPG_VW_FIELD];
  wire v_b = vw[`HDVPG_VW_BLANK];
  wire h_b = hw[`HDVPG_HW_EAV];
  wire [9:0] xyz_word = {1'b1, f_b, v_b, h_b, v_b ^ h_b, f_b ^ h_b, f_b ^ v_b, f_b ^ v_b ^ h_b, 2'b00};
  wire in_trs = hw[`HDVPG_HW_TRS];
  wire [1:0] trs_idx = hcnt_q[1:0];
  wire [9:0] trs_word = (trs_idx == `HDVPG_TRS_W0_IDX) ? `HDVPG_TRS_W0 :
    ((trs_idx == `HDVPG_TRS_XYZ_IDX) ? xyz_word : `HDVPG_TRS_W1);
  // data independent of clock rate
  // Rate and scan variants share tables; only the clock source differs.
  always @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      luma <= `HDVPG_Y_BLACK;
      chroma <= `HDVPG_C_ZERO;
      trs <= 1'b0;
      xyz <= 1'b0;
      field <= 1'b0;
      v_blank <= 1'b0;
      h_blank <= 1'b0;
      line_num <= `HDVPG_LINE_FIRST;
    end
    else
    begin
      trs <= in_trs;
      xyz <= in_trs && trs_idx == `HDVPG_TRS_XYZ_IDX;
      field <= f_b;
      v_blank <= v_b;
      h_blank <= hw[`HDVPG_HW_BLANK];
      line_num <= line_q;
      luma <= in_trs ? trs_word : (cw[`HDVPG_CW_RAMP] ? ramp_y : cw[`HDVPG_CW_Y]);
      chroma <= in_trs ? trs_word : cw[`HDVPG_CW_C];
    end
  end

endmodule
`default_nettype wire

// >>> dv/hdvpg_assertions.sv
// Concurrent checks on the pattern generator's stream and bus ports.
// Assumes it is bound onto hdvpg_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module hdvpg_checker
(
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Bus
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  // Stream
  input wire [9:0] luma,
  input wire [9:0] chroma,
  input wire trs,
  input wire xyz,
  input wire h_blank,
  input wire [10:0] line_num
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  trs_four_a: assert property (
    $rose(trs) |-> trs[*4] ##1 !trs) else $error("trs not four words");
  xyz_last_a: assert property (
    $rose(trs) |-> !xyz[*3] ##1 xyz) else $error("xyz not on fourth word");
  xyz_in_trs_a: assert property (
    xyz |-> trs) else $error("xyz outside trs");
  trs_lead_a: assert property (
    $rose(trs) |-> luma == 10'h3ff && chroma == 10'h3ff ##1 luma == 10'h000 && chroma == 10'h000
      ##1 luma == 10'h000 && chroma == 10'h000) else $error("trs lead words wrong");
  xyz_word_a: assert property (
    xyz |-> luma[9] && luma[1:0] == 2'h0 && luma[5:2] == {luma[7] ^ luma[6], luma[8] ^ luma[6],
      luma[8] ^ luma[7], luma[8] ^ luma[7] ^ luma[6]}) else $error("xyz word coding wrong");
  blank_level_a: assert property (
    h_blank && !trs |-> luma == 10'h040 && chroma == 10'h200) else $error("blanking level wrong");
  after_trs_a: assert property (
    xyz |=> !trs && h_blank == $past(luma[6])) else $error("region after trs wrong");
  line_step_a: assert property (
    $changed(line_num) && line_num != 11'h001 |-> line_num == $past(line_num) + 11'h001)
    else $error("line number step wrong");
  line_hold_a: assert property (
    $changed(line_num) |=> $stable(line_num)[*8]) else $error("line number moved twice");
  wait_one_a: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait wrong");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind hdvpg_top hdvpg_checker chk_u (.core_clk(core_clk), .resetn(resetn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .luma(luma), .chroma(chroma),
  .trs(trs), .xyz(xyz), .h_blank(h_blank), .line_num(line_num));
`default_nettype wire

// >>> dv/hdvpg_sdi_model.sv
// Transmitter-side model: watches timing references and takes the line number.
// Assumes the generator's stream ports and its video clock.
`timescale 1ns/1ps
`default_nettype none
module hdvpg_sdi_model
(
  // Clock and reset
  input wire core_clk,
  input wire resetn,
  // Stream in
  input wire [9:0] luma,
  input wire [9:0] chroma,
  input wire trs,
  input wire xyz,
  input wire [10:0] line_num,
  // Findings
  output var int bad_words,
  output var int eav_seen,
  output var logic [10:0] eav_line
);
  logic [1:0] word_q;
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      word_q <= 2'h0;
      bad_words <= 0;
      eav_seen <= 0;
      eav_line <= 11'h000;
    end
    else
    begin
      word_q <= trs ? word_q + 2'h1 : 2'h0;
      if (trs && (((word_q == 2'h3) !== xyz) || (word_q != 2'h3 &&
          ({luma, chroma} !== (word_q == 2'h0 ? 20'hfffff : 20'h00000)))))
        bad_words <= bad_words + 1;
      if (xyz && luma[6])
      begin
        eav_seen <= eav_seen + 1;
        eav_line <= line_num;
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the pattern generator with a transmitter model.
// Assumes the default 1080 table loaded for every standard code.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk, resetn, avs_read, avs_write;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, rd;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, trs, xyz, field, v_blank, h_blank;
  wire [9:0] luma, chroma;
  wire [10:0] line_num;
  wire [10:0] eav_line;
  int bad_words, eav_seen, num_errors, checked, cyc, t0, ln, bad, alt, i;
  logic [19:0] p1, p2, bar_ref, bar_opt;
  hdvpg_top dut_u (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .luma(luma), .chroma(chroma),
    .trs(trs), .xyz(xyz), .field(field), .v_blank(v_blank), .h_blank(h_blank), .line_num(line_num));
  hdvpg_sdi_model mdl_u (.core_clk(core_clk), .resetn(resetn), .luma(luma), .chroma(chroma), .trs(trs),
    .xyz(xyz), .line_num(line_num), .bad_words(bad_words), .eav_seen(eav_seen), .eav_line(eav_line));
  ////////////////////////////////////////////////////////////////////////////
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Holds the request until the edge that samples waitrequest low.
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task wait_xyz(input logic h);
    int n;
    @(posedge core_clk);
    for (n = 0; n < 3000 && !(xyz === 1'b1 && luma[6] === h); n++) @(posedge core_clk);
  endtask
  task complete_run;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task test_regs;
    for (i = 0; i < 8; i++)
    begin
      bus(1'b1, 4'h0, i);
      bus(1'b0, 4'h0, 32'h0);
      check("ctrl_std", rd, i);
    end
    bus(1'b1, 4'h0, 32'hffffffff);
    bus(1'b0, 4'h0, 32'h0);
    check("ctrl_all", rd, 32'h00003fff);
    bus(1'b1, 4'h0, 32'h00000002);
    bus(1'b0, 4'h8, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'b0, 4'h4, 32'h0);
    check("status", {rd[17:16], rd[10:0]}, {2'h2, 11'h001});
    bus(1'b1, 4'h0, 32'h00002302);
  endtask
  task test_line;
    wait_xyz(1'b1);
    t0 = cyc;
    ln = line_num;
    wait_xyz(1'b0);
    check("sav_offset", cyc - t0, 276);
    wait_xyz(1'b1);
    check("line_len", cyc - t0, 2200);
    @(posedge core_clk);
    check("line_step", line_num, ln + 1);
    check("eav_line", eav_line, ln + 1);
  endtask
  // Walks the blanking lines into the first picture line and its bar steps.
  task test_frame;
    for (i = 0; i < 45 && line_num !== 11'd42; i++)
    begin
      wait_xyz(1'b1);
      check("v_flag", luma[7], line_num < 42);
    end
    wait_xyz(1'b0);
    bad = 0;
    alt = 0;
    for (i = 280; i < 2200; i++)
    begin
      @(posedge core_clk);
      if ((i - 280) % 240 >= 2 && {luma, chroma} !== p2) bad++;
      if (v_blank !== 1'b0) bad++;
      if (chroma !== p1[9:0]) alt++;
      if (i == 400) bar_ref = {luma, chroma};
      if (i == 2100) bar_opt = {luma, chroma};
      p2 = p1;
      p1 = {luma, chroma};
    end
    check("bar_steps", bad, 0);
    check("chroma_alt", alt > 0, 1);
    check("opt_region", bar_opt, bar_ref);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    resetn = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    {num_errors, checked, cyc, p1, p2, bar_ref} = '0;
    bar_opt = '1;
    repeat (4) @(posedge core_clk);
    check("reset_out", {line_num, trs, luma}, {11'h001, 1'b0, 10'h040});
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    test_regs();
    test_line();
    test_frame();
    check("tx_words", bad_words, 0);
    check("tx_eavs", eav_seen > 40, 1);
    complete_run();
  end
  initial
  begin
    repeat (98000) @(posedge core_clk);
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
